//--- tcd_dma_core.sv
// Purpose: Two-channel DMA core with arbitration, address and bus modes.
// Assumes: System bus grant and ready come from the bus state controller.
// Notes: Registers on Avalon-MM; memSize 3 means a 16-byte unit of 4 words.
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tcd_regs.svh"
module tcd_dma_core (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [1:0]  externalTransferRequest,
   input  wire logic        serialRxRequest,
   input  wire logic        serialTxRequest,
   input  wire logic        nmiEvent,
   input  wire logic        addrErrorEvent,
   output logic             busRequest,
   input  wire logic        busGrant,
   output logic      [31:0] memAddr,
   output logic             memRead,
   output logic             memWrite,
   output logic      [1:0]  memSize,
   output logic      [31:0] memWdata,
   input  wire logic [31:0] memRdata,
   input  wire logic        memReady,
   output logic      [1:0]  transferAckStrobe
);
   import tcd_pkg::*;

   tcd_state_t  state_q;
   tcd_ctrl_t   ctrl_q [2];
   logic [31:0] src_q [2];
   logic [31:0] dst_q [2];
   logic [31:0] cnt_q [2];
   logic        masterEn_q;
   logic        nmiFlag_q;
   logic        addrErr_q;
   logic        prioMode_q;
   logic        prio_q;
   logic        cur_q;
   logic [1:0]  beat_q;
   logic        resp_q;
   logic [31:0] rdata_q;
   logic [1:0]  extPrev_q;
   logic [1:0]  edgePend_q;
   logic [1:0]  req;
   logic [1:0]  chWrite;
   logic        pick;
   logic        top;
   logic        beatDone;
   logic        unitDone;
   logic        keepBus;
   logic        operWrite;
   logic        cs;

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Every access answers one cycle after it is first seen.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         resp_q <= 1'b0;
      end else begin
         resp_q <= (avs_read | avs_write) & ~resp_q;
      end
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~resp_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & ~resp_q) begin
         avs_readdata <= rdata_q;
      end
   end

   always_comb begin
      rdata_q = 32'h0;
      cs = avs_address[4];
      if (avs_address == `TCD_OFF_OPER) begin
         rdata_q = {28'h0, prioMode_q, addrErr_q, nmiFlag_q, masterEn_q};
      end else if (avs_address[5] == 1'b0) begin
         if (avs_address[3:0] == `TCD_OFF_CTRL) begin
            rdata_q = {21'h0, ctrl_q[cs]};
         end else if (avs_address[3:0] == `TCD_OFF_SRC) begin
            rdata_q = src_q[cs];
         end else if (avs_address[3:0] == `TCD_OFF_DST) begin
            rdata_q = dst_q[cs];
         end else if (avs_address[3:0] == `TCD_OFF_CNT) begin
            rdata_q = cnt_q[cs];
         end
      end
   end

   assign operWrite = avs_write & resp_q & (avs_address == `TCD_OFF_OPER);

   // Flags set by hardware win over a software clear in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {prioMode_q, addrErr_q, nmiFlag_q, masterEn_q} <= `TCD_OPER_RST;
      end else begin
         if (operWrite & avs_byteenable[0]) begin
            masterEn_q <= avs_writedata[`TCD_OPER_ME];
            prioMode_q <= avs_writedata[`TCD_OPER_PRIO];
            nmiFlag_q  <= avs_writedata[`TCD_OPER_NMI] & nmiFlag_q;
            addrErr_q  <= avs_writedata[`TCD_OPER_AE] & addrErr_q;
         end
         if (nmiEvent) begin
            nmiFlag_q <= 1'b1;
         end
         if (addrErrorEvent) begin
            addrErr_q <= 1'b1;
         end
      end
   end

   assign beatDone = memReady & ((state_q == ST_WRITE) |
                                 (state_q == ST_SINGLE));
   assign unitDone = beatDone &
      (ctrl_q[cur_q][`TCD_CTRL_SZ_LO +: 2] != 2'h3 |
       beat_q == `TCD_UNIT_BEATS);

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_ch
         logic        en;
         logic        sing;
         logic        ds;
         logic        dl;
         logic        extLvl;
         logic        edgeHit;
         logic        mine;
         logic [31:0] step;
         tcd_reqsrc_t rs;
         assign sing = ctrl_q[c][`TCD_CTRL_SINGLE];
         assign ds   = ctrl_q[c][`TCD_CTRL_DS];
         assign dl   = ctrl_q[c][`TCD_CTRL_DL];
         assign rs   = tcd_reqsrc_t'(ctrl_q[c][`TCD_CTRL_SRC_LO +: 2]);
         assign mine = unitDone & (cur_q == 1'(c));
         assign step = (ctrl_q[c][`TCD_CTRL_SZ_LO +: 2] == 2'h3) ? 32'h4 :
            32'h1 << ctrl_q[c][`TCD_CTRL_SZ_LO +: 2];
         assign en = ctrl_q[c][`TCD_CTRL_EN] & masterEn_q &
                     ~ctrl_q[c][`TCD_CTRL_TE] & ~nmiFlag_q &
                     ~addrErr_q;
         assign extLvl = ds ? edgePend_q[c] :
            (externalTransferRequest[c] == dl);
         assign edgeHit = dl ?
            (externalTransferRequest[c] & ~extPrev_q[c]) :
            (~externalTransferRequest[c] & extPrev_q[c]);
         always_comb begin
            if (!en) begin
               req[c] = 1'b0;
            end else if (sing) begin
               req[c] = extLvl;
            end else begin
               case (rs)
                  SRC_EXT:  req[c] = extLvl;
                  SRC_SRX:  req[c] = serialRxRequest;
                  SRC_STX:  req[c] = serialTxRequest;
                  default:  req[c] = 1'b1;
               endcase
            end
         end
         assign chWrite[c] = avs_write & resp_q & ~avs_address[5] &
                             (avs_address[4] == 1'(c));
         // A burst keeps its edge request until the end condition.
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               extPrev_q[c]  <= 1'b0;
               edgePend_q[c] <= 1'b0;
            end else begin
               extPrev_q[c] <= externalTransferRequest[c];
               // Edges count only under edge sensing, so a level setup
               // leaves no stale request for a later edge setup.
               if (edgeHit & ds) begin
                  edgePend_q[c] <= 1'b1;
               end else if (mine & (~ctrl_q[c][`TCD_CTRL_BURST] |
                                    cnt_q[c] == 32'h1)) begin
                  edgePend_q[c] <= 1'b0;
               end
            end
         end
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               ctrl_q[c] <= `TCD_CTRL_RST;
               src_q[c]  <= 32'h0;
               dst_q[c]  <= 32'h0;
               cnt_q[c]  <= 32'h0;
            end else begin
               if (chWrite[c]) begin
                  if (avs_address[3:0] == `TCD_OFF_CTRL) begin
                     ctrl_q[c] <= 11'(merge({21'h0, ctrl_q[c]},
                        avs_writedata & ~(32'h1 << `TCD_CTRL_TE) |
                        {31'h0, ctrl_q[c][`TCD_CTRL_TE]
                                & avs_writedata[`TCD_CTRL_TE]} <<
                        `TCD_CTRL_TE, avs_byteenable));
                  end else if (avs_address[3:0] == `TCD_OFF_SRC) begin
                     src_q[c] <= merge(src_q[c], avs_writedata,
                                       avs_byteenable);
                  end else if (avs_address[3:0] == `TCD_OFF_DST) begin
                     dst_q[c] <= merge(dst_q[c], avs_writedata,
                                       avs_byteenable);
                  end else if (avs_address[3:0] == `TCD_OFF_CNT) begin
                     cnt_q[c] <= merge(cnt_q[c], avs_writedata,
                                       avs_byteenable);
                  end
               end
               if (beatDone & (cur_q == 1'(c))) begin
                  // Single mode only moves the address-side pointer.
                  if (!sing | !ctrl_q[c][`TCD_CTRL_ACS]) begin
                     src_q[c] <= src_q[c] + step;
                  end
                  if (!sing | ctrl_q[c][`TCD_CTRL_ACS]) begin
                     dst_q[c] <= dst_q[c] + step;
                  end
               end
               if (mine) begin
                  cnt_q[c] <= cnt_q[c] - 32'h1;
                  if (cnt_q[c] == 32'h1) begin
                     ctrl_q[c][`TCD_CTRL_TE] <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   assign top  = prioMode_q ? prio_q : 1'b0;
   assign pick = req[top] ? top : ~top;
   // Only a burst channel keeps the bus across a unit boundary.
   assign keepBus = ctrl_q[cur_q][`TCD_CTRL_BURST] & (req != 2'h0);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prio_q <= 1'b0;
      end else if (unitDone) begin
         prio_q <= ~cur_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         cur_q   <= 1'b0;
         beat_q  <= 2'h0;
         memWdata <= 32'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (req != 2'h0) begin
                  state_q <= ST_GRANT;
               end
            end
            ST_GRANT: begin
               if (busGrant & (req != 2'h0)) begin
                  cur_q   <= pick;
                  beat_q  <= 2'h0;
                  state_q <= ctrl_q[pick][`TCD_CTRL_SINGLE] ?
                             ST_SINGLE : ST_READ;
               end else if (req == 2'h0) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_READ: begin
               if (memReady) begin
                  memWdata <= memRdata;
                  state_q  <= ST_WRITE;
               end
            end
            ST_WRITE, ST_SINGLE: begin
               if (unitDone) begin
                  state_q <= ST_NEXT;
               end else if (beatDone) begin
                  beat_q  <= beat_q + 2'h1;
                  state_q <= (state_q == ST_SINGLE) ? ST_SINGLE : ST_READ;
               end
            end
            ST_NEXT: begin
               if (keepBus) begin
                  cur_q   <= pick;
                  beat_q  <= 2'h0;
                  state_q <= ctrl_q[pick][`TCD_CTRL_SINGLE] ?
                             ST_SINGLE : ST_READ;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign busRequest = (state_q != ST_IDLE) &
                       ~((state_q == ST_NEXT) & ~keepBus);
   assign memRead  = (state_q == ST_READ) |
      ((state_q == ST_SINGLE) & ~ctrl_q[cur_q][`TCD_CTRL_ACS]);
   assign memWrite = (state_q == ST_WRITE) |
      ((state_q == ST_SINGLE) & ctrl_q[cur_q][`TCD_CTRL_ACS]);
   assign memSize  = ctrl_q[cur_q][`TCD_CTRL_SZ_LO +: 2];
   assign memAddr  = ((state_q == ST_READ) |
      ((state_q == ST_SINGLE) & ~ctrl_q[cur_q][`TCD_CTRL_ACS])) ?
      src_q[cur_q] : dst_q[cur_q];
   always_comb begin
      transferAckStrobe = 2'h0;
      if ((state_q == ST_SINGLE) |
          (state_q == ST_READ & ~ctrl_q[cur_q][`TCD_CTRL_ACS]) |
          (state_q == ST_WRITE & ctrl_q[cur_q][`TCD_CTRL_ACS])) begin
         transferAckStrobe[cur_q] = 1'b1;
      end
   end

   property p_reset_prio;
      @(posedge clk) $fell(sys_rst) |-> prio_q == 1'b0;
   endproperty
   a_reset_prio: assert property (p_reset_prio)
      else $error("priority not channel 0 after reset");

   property p_rr_swap;
      @(posedge clk) disable iff (sys_rst)
      unitDone |=> prio_q == ~$past(cur_q);
   endproperty
   a_rr_swap: assert property (p_rr_swap)
      else $error("round-robin order not handed over");

   property p_fixed_pick;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_GRANT && busGrant && !prioMode_q && req[0])
      |=> cur_q == 1'b0;
   endproperty
   a_fixed_pick: assert property (p_fixed_pick)
      else $error("fixed priority did not pick channel 0");

   property p_dual_rw;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_READ && memReady) |=>
      state_q == ST_WRITE && memWdata == $past(memRdata);
   endproperty
   a_dual_rw: assert property (p_dual_rw)
      else $error("read data not held for write");

   property p_single_one;
      @(posedge clk) disable iff (sys_rst)
      state_q == ST_SINGLE |-> (memRead ^ memWrite) &&
      transferAckStrobe[cur_q];
   endproperty
   a_single_one: assert property (p_single_one)
      else $error("single cycle lacks strobe or direction");

   property p_ack_cycle;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_WRITE && transferAckStrobe != 2'h0) |->
      ctrl_q[cur_q][`TCD_CTRL_ACS];
   endproperty
   a_ack_cycle: assert property (p_ack_cycle)
      else $error("strobe in write cycle with read select");

   property p_steal_release;
      @(posedge clk) disable iff (sys_rst)
      (unitDone && !ctrl_q[cur_q][`TCD_CTRL_BURST]) |=> !busRequest;
   endproperty
   a_steal_release: assert property (p_steal_release)
      else $error("cycle-steal unit kept the bus");

   property p_gate;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_IDLE && (!masterEn_q || nmiFlag_q || addrErr_q))
      |=> state_q == ST_IDLE;
   endproperty
   a_gate: assert property (p_gate)
      else $error("transfer started while disabled");

   property p_single_ext;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_GRANT && busGrant && req != 2'h0 &&
       ctrl_q[pick][`TCD_CTRL_SINGLE]) |-> ctrl_q[pick][`TCD_CTRL_DS] ?
      edgePend_q[pick] :
      externalTransferRequest[pick] == ctrl_q[pick][`TCD_CTRL_DL];
   endproperty
   a_single_ext: assert property (p_single_ext)
      else $error("single transfer not from external pin");

   c_single: cover property (@(posedge clk) state_q == ST_SINGLE);
   c_dual: cover property (@(posedge clk)
      state_q == ST_READ ##1 state_q == ST_WRITE);
   c_burst: cover property (@(posedge clk)
      state_q == ST_NEXT && keepBus);
   c_swap: cover property (@(posedge clk) unitDone && cur_q);
endmodule
`default_nettype wire

//--- tcd_regs.svh
// Purpose: Register offsets, field positions and reset values of the DMA core.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one word per register.
// Notes:   Channel 1 registers sit one channel stride above channel 0.
`ifndef TCD_REGS_SVH
`define TCD_REGS_SVH
`define TCD_CH_STRIDE   6'h10
`define TCD_OFF_CTRL    6'h00
`define TCD_OFF_SRC     6'h04
`define TCD_OFF_DST     6'h08
`define TCD_OFF_CNT     6'h0c
`define TCD_OFF_OPER    6'h20
`define TCD_CTRL_EN     0
`define TCD_CTRL_TE     1
`define TCD_CTRL_BURST  2
`define TCD_CTRL_ACS    3
`define TCD_CTRL_SINGLE 4
`define TCD_CTRL_SRC_LO 5
`define TCD_CTRL_DS     7
`define TCD_CTRL_DL     8
`define TCD_CTRL_SZ_LO  9
`define TCD_OPER_ME     0
`define TCD_OPER_NMI    1
`define TCD_OPER_AE     2
`define TCD_OPER_PRIO   3
`define TCD_CTRL_RST    11'h000
`define TCD_OPER_RST    4'h0
`define TCD_UNIT_BEATS  2'h3
`endif

//--- tcd_pkg.sv
// Purpose: Types shared by the DMA core.
// Assumes: Nothing beyond the register header.
// Notes:   States are one-hot.
package tcd_pkg;
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_GRANT  = 6'h02,
      ST_READ   = 6'h04,
      ST_WRITE  = 6'h08,
      ST_SINGLE = 6'h10,
      ST_NEXT   = 6'h20
   } tcd_state_t;
   typedef enum logic [1:0] {
      SRC_EXT  = 2'h0,
      SRC_SRX  = 2'h1,
      SRC_STX  = 2'h2,
      SRC_AUTO = 2'h3
   } tcd_reqsrc_t;
   typedef logic [10:0] tcd_ctrl_t;
endpackage

//--- tcd_bus_model.sv
// Purpose: System bus partner: grant, memory and beat completion.
// Assumes: One beat completes per memReady pulse.
// Notes:   Wait states alternate, so prompt and slow answers both occur.
`timescale 1ns/1ns
`default_nettype none
module tcd_bus_model (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        logClr,
   input  wire logic        busRequest,
   output logic             busGrant,
   input  wire logic [31:0] memAddr,
   input  wire logic        memRead,
   input  wire logic        memWrite,
   input  wire logic [31:0] memWdata,
   output logic      [31:0] memRdata,
   output logic             memReady,
   input  wire logic [1:0]  transferAckStrobe
);
   logic [31:0] mem [0:255];
   logic [34:0] logQ [$];
   logic [1:0]  waitCnt = 2'h0;
   logic        slow = 1'b0;
   logic [31:0] lastQ = 32'h0;
   int          grants = 0;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 32'ha5000000 | i;
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         busGrant <= 1'b0;
      end else begin
         if (logClr) grants <= 0;
         else if (busRequest && !busGrant) grants <= grants + 1;
         busGrant <= busRequest;
      end
   end
   // Data left on the bus outside a read is the inverse of the last word.
   assign memRdata = memRead ? mem[memAddr[9:2]] : ~lastQ;
   always @(posedge clk) begin
      memReady <= 1'b0;
      if (logClr) logQ.delete();
      if (!sys_rst && (memRead || memWrite) && !memReady) begin
         if (waitCnt == 2'h0) begin
            memReady <= 1'b1;
            slow <= !slow;
            waitCnt <= slow ? 2'h0 : 2'h3;
         end else begin
            waitCnt <= waitCnt - 2'h1;
         end
      end
      if (memReady && (memRead || memWrite)) begin
         logQ.push_back({memWrite, transferAckStrobe, memAddr});
         if (memWrite) mem[memAddr[9:2]] <= memWdata;
         if (memRead) lastQ <= mem[memAddr[9:2]];
      end
   end
endmodule
`default_nettype wire

//--- tb_two_channel_dma_arbiter_modes.sv
// Purpose: Self-checking bench of the two-channel DMA core.
// Assumes: Registers reached over Avalon-MM, one-cycle wait answer.
// Notes:   Requests come from auto-request, pin 0 and both serial lines.
`timescale 1ns/1ns
`default_nettype none
module tb_two_channel_dma_arbiter_modes;
   import tcd_pkg::*;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  extReq = 2'h0;
   logic        nmiEvent = 1'b0;
   logic        aeEvent = 1'b0;
   logic        logClr = 1'b0;
   logic [1:0]  serReq = 2'h0;
   logic        busRequest, busGrant, memRead, memWrite, memReady;
   logic [31:0] memAddr, memWdata, memRdata, rd;
   logic [1:0]  memSize, ackStrobe;
   int          n_errors = 0;
   int          comparisons = 0;
   initial forever #2 clk = ~clk;
   tcd_dma_core uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .externalTransferRequest(extReq), .serialRxRequest(serReq[0]),
      .serialTxRequest(serReq[1]), .nmiEvent(nmiEvent),
      .addrErrorEvent(aeEvent),
      .busRequest(busRequest), .busGrant(busGrant), .memAddr(memAddr),
      .memRead(memRead), .memWrite(memWrite), .memSize(memSize),
      .memWdata(memWdata), .memRdata(memRdata), .memReady(memReady),
      .transferAckStrobe(ackStrobe));
   tcd_bus_model bus (.clk(clk), .sys_rst(sys_rst), .busRequest(busRequest),
      .busGrant(busGrant), .memAddr(memAddr), .memRead(memRead),
      .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata),
      .memReady(memReady), .transferAckStrobe(ackStrobe),
      .logClr(logClr));
   task automatic summarize;
      $display("mismatches %0d of %0d compares", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [34:0] got, input logic [34:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic avsCycle(input logic wr, input logic [5:0] a,
                           input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic waitLog(input int cnt);
      int n;
      n = 0;
      while (bus.logQ.size() < cnt && n < 600) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      if (n >= 600) begin
         n_errors++;
         summarize();
      end
   endtask
   // Source 0x100 or 0x200, destination 0x80 above, control written last.
   task automatic startCh(input int ch, input logic [31:0] ctrl,
                          input logic [31:0] cnt);
      avsCycle(1'b1, 6'(ch * 16 + 4), 32'h100 + ch * 32'h100);
      avsCycle(1'b1, 6'(ch * 16 + 8), 32'h180 + ch * 32'h100);
      avsCycle(1'b1, 6'(ch * 16 + 12), cnt);
      logClr <= 1'b1;
      @(posedge clk);
      logClr <= 1'b0;
      avsCycle(1'b1, 6'(ch * 16), ctrl);
   endtask
   task automatic pair(input logic [31:0] oper, input logic [31:0] first);
      avsCycle(1'b1, 6'h20, 32'h0);
      startCh(0, 32'h461, 1);
      startCh(1, 32'h461, 1);
      avsCycle(1'b1, 6'h20, oper);
      waitLog(4);
      check(bus.logQ[0][31:0], first);
      check(bus.logQ[2][31:0], first ^ 32'h300);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      avsCycle(1'b0, 6'h00, 32'h0);
      check(rd, 32'h0);
      avsCycle(1'b0, 6'h20, 32'h0);
      check(rd, 32'h0);
      avsCycle(1'b0, 6'h3c, 32'h0);
      check(rd, 32'h0);
      pair(32'h9, 32'h100);
      repeat (2) begin
         startCh(0, 32'h461, 1);
         waitLog(2);
      end
      pair(32'h9, 32'h200);
      pair(32'h1, 32'h100);
      startCh(0, 32'h461, 2);
      waitLog(4);
      check(bus.logQ[0][34:32], 3'b001);
      check(bus.logQ[1][34:32], 3'b100);
      check(bus.mem[8'h61], 32'ha5000041);
      check(bus.grants, 2);
      repeat (30) @(posedge clk);
      check(bus.logQ.size(), 4);
      avsCycle(1'b0, 6'h00, 32'h0);
      check(rd[1], 1'b1);
      startCh(0, 32'h661, 1);
      waitLog(8);
      check(bus.logQ[7][31:0], 32'h18c);
      check(memSize, 2'h3);
      check(bus.grants, 1);
      check(bus.mem[8'h63], 32'ha5000043);
      startCh(1, 32'h06d, 2);
      waitLog(4);
      check(bus.logQ[1][34:32], 3'b110);
      check(bus.logQ[3][31:0], 32'h281);
      check(bus.grants, 1);
      for (int acs = 0; acs < 2; acs++) begin
         startCh(0, 32'h515 | (acs << 3), 2);
         repeat (30) @(posedge clk);
         check(bus.logQ.size(), 0);
         extReq <= 2'h1;
         waitLog(2);
         extReq <= 2'h0;
         repeat (20) @(posedge clk);
         check(bus.logQ.size(), 2);
         check(bus.logQ[1][31:0], 32'h104 + acs * 32'h80);
         check(bus.logQ[1][34:32], {acs[0], 2'b01});
         check(bus.grants, 1);
      end
      startCh(0, 32'h599, 2);
      repeat (2) begin
         extReq <= 2'h1;
         repeat (40) @(posedge clk);
         extReq <= 2'h0;
         repeat (10) @(posedge clk);
      end
      check(bus.logQ.size(), 2);
      for (int s = 0; s < 2; s++) begin
         startCh(1, 32'h421 + s * 32'h20, 1);
         repeat (20) @(posedge clk);
         check(bus.logQ.size(), 0);
         serReq <= 2'(s + 1);
         waitLog(2);
         check(bus.logQ[0][31:0], 32'h200);
         serReq <= 2'h0;
      end
      nmiEvent <= 1'b1;
      aeEvent <= 1'b1;
      @(posedge clk);
      nmiEvent <= 1'b0;
      aeEvent <= 1'b0;
      avsCycle(1'b0, 6'h20, 32'h0);
      check(rd[2:1], 2'b11);
      startCh(0, 32'h461, 1);
      repeat (30) @(posedge clk);
      check(bus.logQ.size(), 0);
      avsCycle(1'b1, 6'h20, 32'h1);
      waitLog(2);
      summarize();
   end
endmodule
`default_nettype wire
